/* File: include/ccr_pkg.sv */
package ccr_pkg;

  // ********************************************************
  // Register map and field layout
  // ********************************************************
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] CFG_OFS       = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam int          ART_BIT       = 7;
  localparam int          RST_BIT       = 5;
  localparam int          LVL_BIT       = 4;
  localparam int          HALT_BIT      = 3;
  localparam int          SEL_LSB       = 0;
  localparam int          SEL_W         = 3;
  localparam logic [7:0]  CFG_RESET     = 8'h08;
  localparam logic [7:0]  CFG_WMASK     = 8'hBF;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_PIN_BIT  = 1;
  localparam int          STAT_SEQ_BIT  = 2;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int REF_CLK_HZ      = 100_000_000;
  localparam int AUTO_RST_NS     = 40_000;
  localparam int AUTO_RST_CYC    = (AUTO_RST_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CARD_CLK_MAX_HZ = 24_000_000;
  localparam int LINK_CLK_HZ     = 15_625_000;

  // ********************************************************
  // Types
  // ********************************************************
  typedef logic [SEL_W-1:0] ccr_sel_t;

  typedef struct packed {
    logic     halt;
    logic     level;
    ccr_sel_t sel;
  } ccr_clkcfg_t;

  localparam ccr_clkcfg_t CLKCFG_RESET = '{halt: 1'b1, level: 1'b0, sel: 3'h0};

  typedef enum {RS_LOW, RS_WAIT, RS_HIGH} ccr_rst_state_t;

  // Half period of the card clock in link clock cycles
  function automatic logic [7:0] ccr_half_period(input ccr_sel_t s);
    case (s)
      3'h0:    ccr_half_period = 8'h01;
      3'h1:    ccr_half_period = 8'h02;
      3'h2:    ccr_half_period = 8'h04;
      3'h3:    ccr_half_period = 8'h08;
      3'h4:    ccr_half_period = 8'h03;
      3'h5:    ccr_half_period = 8'h06;
      3'h6:    ccr_half_period = 8'h10;
      default: ccr_half_period = 8'h20;
    endcase
  endfunction : ccr_half_period

endpackage : ccr_pkg

/* File: include/ccr_cfg_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface ccr_cfg_if;
  ccr_pkg::ccr_clkcfg_t cfg;

  modport src (output cfg);
  modport dst (input cfg);
endinterface : ccr_cfg_if

`default_nettype wire

/* File: src/ccr_cfg_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module ccr_cfg_sync (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire ccr_pkg::ccr_clkcfg_t refCfg,
  output logic                      busy,
  input  wire logic                 link_clk,
  input  wire logic                 linkRst_b,
  ccr_cfg_if.src                    cfgIf
);
  import ccr_pkg::*;

  // ********************************************************
  // Reference side: word held stable while in flight
  // ********************************************************
  ccr_clkcfg_t hold_reg;
  logic        reqTgl_reg;
  logic        ackMeta_reg;
  logic        ackSync_reg;
  logic        reqMeta_reg;
  logic        reqSync_reg;
  logic        ackTgl_reg;
  ccr_clkcfg_t linkCfg_reg;

  assign busy = reqTgl_reg != ackSync_reg;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      hold_reg   <= CLKCFG_RESET;
      reqTgl_reg <= 1'b0;
    end
    else if (!busy && refCfg != hold_reg)
    begin
      hold_reg   <= refCfg;
      reqTgl_reg <= ~reqTgl_reg;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ackMeta_reg <= 1'b0;
      ackSync_reg <= 1'b0;
    end
    else
    begin
      ackMeta_reg <= ackTgl_reg;
      ackSync_reg <= ackMeta_reg;
    end
  end

  // ********************************************************
  // Link side: take the word once the toggle is seen
  // ********************************************************
  always_ff @(posedge link_clk)
  begin
    if (!linkRst_b)
    begin
      reqMeta_reg <= 1'b0;
      reqSync_reg <= 1'b0;
      ackTgl_reg  <= 1'b0;
      linkCfg_reg <= CLKCFG_RESET;
    end
    else
    begin
      reqMeta_reg <= reqTgl_reg;
      reqSync_reg <= reqMeta_reg;
      if (reqSync_reg != ackTgl_reg)
      begin
        linkCfg_reg <= hold_reg;
        ackTgl_reg  <= reqSync_reg;
      end
    end
  end

  assign cfgIf.cfg = linkCfg_reg;

endmodule : ccr_cfg_sync

`default_nettype wire

/* File: src/ccr_clock_gen.sv */
`timescale 1ns/10ps
`default_nettype none

module ccr_clock_gen #(
  parameter int LINK_HZ = ccr_pkg::LINK_CLK_HZ
) (
  input  wire logic link_clk,
  input  wire logic linkRst_b,
  ccr_cfg_if.dst    cfgIf,
  output logic      cardClockPin
);
  import ccr_pkg::*;

  if (LINK_HZ / 2 > CARD_CLK_MAX_HZ)
  begin : gLinkRateChk
    $error("Link clock too fast for the card clock ceiling");
  end

  logic [7:0] cnt_reg;
  logic       pin_reg;
  logic       running_reg;
  ccr_sel_t   activeSel_reg;
  logic       halfDone;

  assign halfDone     = cnt_reg == ccr_half_period(activeSel_reg) - 8'h01;
  assign cardClockPin = pin_reg;

  // ********************************************************
  // Divider; while running, select and halt only act at a period end
  // ********************************************************
  always_ff @(posedge link_clk)
  begin
    if (!linkRst_b)
    begin
      cnt_reg       <= 8'h00;
      pin_reg       <= 1'b0;
      running_reg   <= 1'b0;
      activeSel_reg <= 3'h0;
    end
    else if (!running_reg)
    begin
      pin_reg       <= cfgIf.cfg.level;
      cnt_reg       <= 8'h00;
      activeSel_reg <= cfgIf.cfg.sel;
      running_reg   <= !cfgIf.cfg.halt;
    end
    else if (halfDone)
    begin
      cnt_reg <= 8'h00;
      if (pin_reg)
      begin
        // High-to-low is a period end: safe point to retune
        activeSel_reg <= cfgIf.cfg.sel;
        running_reg   <= !cfgIf.cfg.halt;
        pin_reg       <= cfgIf.cfg.halt ? cfgIf.cfg.level : 1'b0;
      end
      else
      begin
        pin_reg <= 1'b1;
      end
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

endmodule : ccr_clock_gen

`default_nettype wire

/* File: src/ccr_card_clock_reset_control.sv */
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Writing one to the reset trigger starts a reset sequence shaped by auto transition.
// - Clearing the reset trigger drives the card reset pin low.
// - Stopped clock level sets the static clock pin level while halted.
// - Three-bit select picks the card clock rate; code 0 is fastest, 24 MHz ceiling.
// - Select changes switch the card clock glitch-free, up to two periods late.
// - Reset: halt bit one; trigger, level and select all zero.
module ccr_card_clock_reset_control #(
  parameter int AUTO_CYC = ccr_pkg::AUTO_RST_CYC,
  parameter int LINK_HZ  = ccr_pkg::LINK_CLK_HZ
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       link_clk,
  input  wire logic [ccr_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            cardClockPin,
  output logic                            cardResetPin
);
  import ccr_pkg::*;

  // ********************************************************
  // Elaboration checks
  // ********************************************************
  // Counter is 16 bits wide
  if (AUTO_CYC < 1 || AUTO_CYC > 65535)
  begin : gAutoRangeChk
    $error("Auto reset count out of range");
  end

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [7:0]     cfg_reg;
  logic           ready_reg;
  logic [31:0]    rdata_reg;
  logic           err_reg;
  logic           rstPin_reg;
  logic [15:0]    autoCnt_reg;
  ccr_rst_state_t rstState_reg;
  ccr_rst_state_t rstState_next;
  logic           linkRstMeta_reg;
  logic           linkRst_b_reg;
  logic           accessCycle;
  logic           commit;
  logic           cfgWrite;
  logic           trigger;
  logic           busy;
  logic           autoDone;
  ccr_clkcfg_t    refCfg;

  ccr_cfg_if cfgBus ();

  // ********************************************************
  // Decode
  // ********************************************************
  function automatic logic regHit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    regHit = addr == ofs;
  endfunction : regHit

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = regHit(addr, CFG_OFS) || regHit(addr, STATUS_OFS);
  endfunction : mapped

  // ********************************************************
  // APB slave, one wait state
  // ********************************************************
  assign accessCycle = psel && penable && !ready_reg;
  assign commit      = psel && penable && ready_reg;
  assign pready      = ready_reg;
  assign prdata      = rdata_reg;
  assign pslverr     = err_reg;
  assign cfgWrite    = commit && pwrite && pstrb[0] && regHit(paddr, CFG_OFS);
  assign trigger     = cfgWrite && pwdata[RST_BIT];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= accessCycle;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      err_reg <= 1'b0;
    end
    else if (accessCycle)
    begin
      err_reg <= !mapped(paddr);
    end
    else
    begin
      err_reg <= 1'b0;
    end
  end

  // Read data captured one cycle ahead so it leaves a flop
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rdata_reg <= RD_ZERO;
    end
    else if (accessCycle && !pwrite && regHit(paddr, CFG_OFS))
    begin
      rdata_reg <= {24'h00_0000, cfg_reg};
    end
    else if (accessCycle && !pwrite && regHit(paddr, STATUS_OFS))
    begin
      rdata_reg                <= RD_ZERO;
      rdata_reg[STAT_BUSY_BIT] <= busy;
      rdata_reg[STAT_PIN_BIT]  <= rstPin_reg;
      rdata_reg[STAT_SEQ_BIT]  <= rstState_reg == RS_WAIT;
    end
    else
    begin
      rdata_reg <= RD_ZERO;
    end
  end

  // ********************************************************
  // Configuration register
  // ********************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cfg_reg <= CFG_RESET;
    end
    else if (cfgWrite)
    begin
      // Bit 6 is reserved and reads zero
      cfg_reg <= pwdata[7:0] & CFG_WMASK;
    end
  end

  // ********************************************************
  // Card reset sequence
  // ********************************************************
  assign autoDone = autoCnt_reg == 16'(AUTO_CYC - 1);

  always_comb
  begin
    rstState_next = rstState_reg;
    if (trigger)
    begin
      rstState_next = pwdata[ART_BIT] ? RS_WAIT : RS_HIGH;
    end
    else if (cfgWrite || !cfg_reg[RST_BIT])
    begin
      // Act on the write itself, not a cycle later on the stored bit
      rstState_next = RS_LOW;
    end
    else
    begin
      case (rstState_reg)
        RS_LOW:
        begin
          rstState_next = RS_LOW;
        end
        RS_WAIT:
        begin
          if (autoDone)
            rstState_next = RS_HIGH;
        end
        RS_HIGH:
        begin
          rstState_next = RS_HIGH;
        end
        default:
        begin
          rstState_next = RS_LOW;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rstState_reg <= RS_LOW;
    end
    else
    begin
      rstState_reg <= rstState_next;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      autoCnt_reg <= 16'h0000;
    end
    else if (rstState_reg != RS_WAIT || trigger)
    begin
      autoCnt_reg <= 16'h0000;
    end
    else if (!autoDone)
    begin
      autoCnt_reg <= autoCnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rstPin_reg <= 1'b0;
    end
    else
    begin
      rstPin_reg <= rstState_next == RS_HIGH;
    end
  end

  assign cardResetPin = rstPin_reg;

  // ********************************************************
  // Link domain reset
  // ********************************************************
  always_ff @(posedge link_clk)
  begin
    linkRstMeta_reg <= rst_b;
    linkRst_b_reg   <= linkRstMeta_reg;
  end

  // ********************************************************
  // Card clock: crossing and divider
  // ********************************************************
  // Codes 4 and 5 assume software halted first; no guard here
  assign refCfg.halt  = cfg_reg[HALT_BIT];
  assign refCfg.level = cfg_reg[LVL_BIT];
  assign refCfg.sel   = cfg_reg[SEL_LSB +: SEL_W];

  ccr_cfg_sync u_sync (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .refCfg    (refCfg),
    .busy      (busy),
    .link_clk  (link_clk),
    .linkRst_b (linkRst_b_reg),
    .cfgIf     (cfgBus.src)
  );

  ccr_clock_gen #(
    .LINK_HZ (LINK_HZ)
  ) u_clkgen (
    .link_clk     (link_clk),
    .linkRst_b    (linkRst_b_reg),
    .cfgIf        (cfgBus.dst),
    .cardClockPin (cardClockPin)
  );

endmodule : ccr_card_clock_reset_control

`default_nettype wire

/* File: testbench/ccr_card_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************
// Card side model
// ****************
// Passive card: counts clock edges, drives nothing back
module ccr_card_model (
  input  wire logic        cardClockPin,
  input  wire logic        cardResetPin,
  output var  logic [15:0] clkEdges
);
  initial clkEdges = 16'h0000;
  always @(posedge cardClockPin) clkEdges <= clkEdges + 16'h0001;
endmodule : ccr_card_model

`default_nettype wire

/* File: testbench/ccr_card_clock_reset_control_checker.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************
// Port checker
// ****************
module ccr_checker
  import ccr_pkg::*;
#(
  parameter int AUTO_CYC = 8
) (
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic              link_clk,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              cardClockPin,
  input wire logic              cardResetPin
);
  localparam int         AUTO_D   = AUTO_CYC + 1;
  // Covers handshake plus two slowest periods plus one phase
  localparam int         QUIET    = 1500;
  localparam logic [7:0] HALF [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h06, 8'h10, 8'h20};
  logic [7:0]  cfgShadow_reg;
  logic [10:0] quiet_reg;
  logic [7:0]  runLen_reg;
  logic        pinQ_reg;
  logic        wrCfg;
  assign wrCfg = psel && penable && pready && pwrite && paddr == CFG_OFS && pstrb[0];
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b) cfgShadow_reg <= CFG_RESET;
    else if (wrCfg) cfgShadow_reg <= pwdata[7:0] & CFG_WMASK;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || wrCfg) quiet_reg <= 11'h000;
    else if (quiet_reg != QUIET) quiet_reg <= quiet_reg + 11'h001;
  end
  always_ff @(posedge link_clk)
  begin
    pinQ_reg <= cardClockPin;
    runLen_reg <= (cardClockPin != pinQ_reg) ? 8'h01 : runLen_reg + 8'h01;
  end
  sequence sRstOn;
    wrCfg && pwdata[RST_BIT] && !pwdata[ART_BIT];
  endsequence
  sequence sRstAuto;
    wrCfg && pwdata[RST_BIT] && pwdata[ART_BIT];
  endsequence
  AST_RDY_ONE: assert property (@(posedge ref_clk) disable iff (!rst_b) pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RDY_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_b) psel && $rose(penable) |=> pready)
    else $error("pready not one cycle after access");
  AST_ERR_MAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pready && paddr != CFG_OFS && paddr != STATUS_OFS |-> pslverr && prdata == RD_ZERO)
    else $error("unmapped access not refused");
  AST_RD_CFG: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pready && !pwrite && paddr == CFG_OFS |-> prdata == {24'h000000, cfgShadow_reg})
    else $error("config read mismatch");
  AST_RST_TRIG: assert property (@(posedge ref_clk) disable iff (!rst_b) sRstOn |=> cardResetPin)
    else $error("reset pin not raised");
  AST_RST_AUTO: assert property (@(posedge ref_clk) disable iff (!rst_b) sRstAuto |-> ##AUTO_D cardResetPin)
    else $error("auto reset pin late");
  AST_RST_CLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrCfg && !pwdata[RST_BIT] |=> !cardResetPin)
    else $error("reset pin not lowered");
  AST_HALT_LVL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    quiet_reg == QUIET && cfgShadow_reg[HALT_BIT] |-> cardClockPin == cfgShadow_reg[LVL_BIT])
    else $error("halted clock level wrong");
  AST_HALF_PER: assert property (@(posedge link_clk) disable iff (!rst_b)
    quiet_reg == QUIET && !cfgShadow_reg[HALT_BIT] && cardClockPin != pinQ_reg
    |-> runLen_reg == HALF[cfgShadow_reg[2:0]])
    else $error("card clock phase length wrong");
endmodule : ccr_checker

bind ccr_card_clock_reset_control ccr_checker #(.AUTO_CYC(AUTO_CYC)) i_ccr_checker (.ref_clk, .rst_b, .link_clk,
  .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cardClockPin, .cardResetPin);

`default_nettype wire

/* File: testbench/ccr_card_clock_reset_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************
// Testbench
// ****************
module ccr_card_clock_reset_control_tb_top;
  import ccr_pkg::*;
  localparam int         AUTO     = 8;
  localparam logic [7:0] HALF [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h06, 8'h10, 8'h20};
  logic              ref_clk  = 1'b0;
  logic              link_clk = 1'b0;
  logic              rst_b    = 1'b0;
  logic [ADDR_W-1:0] paddr    = '0;
  logic              psel     = 1'b0;
  logic              penable  = 1'b0;
  logic              pwrite   = 1'b0;
  logic [31:0]       pwdata   = 32'h0;
  logic [3:0]        pstrb    = 4'hF;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              cardClockPin;
  logic              cardResetPin;
  logic [15:0]       clkEdges;
  logic [15:0]       e;
  logic [31:0]       rd;
  logic              er;
  int                n_errors  = 0;
  int                cmp_count = 0;

  always #5 ref_clk = ~ref_clk;
  initial
  begin
    #7.3;
    forever #32 link_clk = ~link_clk;
  end

  ccr_card_clock_reset_control #(.AUTO_CYC(AUTO)) i_ccr_card_clock_reset_control (.ref_clk(ref_clk),
    .rst_b(rst_b), .link_clk(link_clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cardClockPin(cardClockPin), .cardResetPin(cardResetPin));
  ccr_card_model i_ccr_card_model (.cardClockPin(cardClockPin), .cardResetPin(cardResetPin), .clkEdges(clkEdges));

  task test_done;
    $display("Checks %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      n_errors++;
      $display("Error at %0t: expected %h got %h", $time, ex, got);
    end
  endtask : chk

  task chk_pin(input logic ex, input logic got);
    chk({31'h0, ex}, {31'h0, got});
  endtask : chk_pin

  // Answer taken at the rising edge that samples pready high, then released
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d; pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 40) n_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task t_reset;
    apb(CFG_OFS, 1'b0, 32'h0, 4'hF);
    chk(32'h08, rd);
    chk_pin(1'b0, cardResetPin);
    chk_pin(1'b0, cardClockPin);
  endtask : t_reset

  task t_refuse;
    apb(12'h00C, 1'b1, 32'hFF, 4'hF);
    chk(32'h1, {31'h0, er});
    apb(CFG_OFS, 1'b1, 32'h17, 4'hE);
    apb(CFG_OFS, 1'b0, 32'h0, 4'hF);
    chk(32'h08, rd);
  endtask : t_refuse

  task t_card_reset;
    apb(CFG_OFS, 1'b1, 32'h68, 4'hF);
    @(negedge ref_clk);
    chk_pin(1'b1, cardResetPin);
    apb(CFG_OFS, 1'b0, 32'h0, 4'hF);
    chk(32'h28, rd);
    apb(CFG_OFS, 1'b1, 32'h08, 4'hF);
    @(negedge ref_clk);
    chk_pin(1'b0, cardResetPin);
    apb(CFG_OFS, 1'b1, 32'hA8, 4'hF);
    repeat (AUTO) @(negedge ref_clk);
    chk_pin(1'b0, cardResetPin);
    @(negedge ref_clk);
    chk_pin(1'b1, cardResetPin);
    apb(CFG_OFS, 1'b1, 32'h88, 4'hF);
    @(negedge ref_clk);
    chk_pin(1'b0, cardResetPin);
  endtask : t_card_reset

  task t_level;
    apb(CFG_OFS, 1'b1, 32'h18, 4'hF);
    repeat (1500) @(negedge ref_clk);
    chk_pin(1'b1, cardClockPin);
    e = clkEdges;
    repeat (300) @(negedge ref_clk);
    chk({16'h0, e}, {16'h0, clkEdges});
    apb(CFG_OFS, 1'b1, 32'h08, 4'hF);
    repeat (1500) @(negedge ref_clk);
    chk_pin(1'b0, cardClockPin);
  endtask : t_level

  // Order keeps codes 4 and 5 apart from the rest with a halt between
  task t_run;
    logic [2:0] order [8];
    order = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4, 3'h5};
    for (int i = 0; i < 8; i++)
    begin
      if (i == 6)
      begin
        // Halt must have really stopped the clock before the group changes
        apb(CFG_OFS, 1'b1, 32'h08, 4'hF);
        repeat (1500) @(negedge ref_clk);
        chk_pin(1'b0, cardClockPin);
      end
      apb(CFG_OFS, 1'b1, {29'h0, order[i]}, 4'hF);
      repeat (1500) @(negedge ref_clk);
      @(negedge link_clk);
      e = clkEdges;
      repeat (384) @(negedge link_clk);
      chk(32'd384 / (32'd2 * HALF[order[i]]), {16'h0, clkEdges - e});
    end
    apb(CFG_OFS, 1'b1, 32'h08, 4'hF);
  endtask : t_run

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end

  // Reset spans link edges too, the link side resets from a synchronised copy
  initial
  begin
    repeat (5) @(posedge link_clk);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_refuse();
    t_card_reset();
    t_level();
    t_run();
    test_done();
  end
endmodule : ccr_card_clock_reset_control_tb_top

`default_nettype wire
